// [hdl/rfr_pkg.sv]
package rfr_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ         = 200000;  // system clock rate
  localparam int SETTLE_MS       = 25;      // settle time after sleep release
  localparam int SETTLE_CYCLES   = SETTLE_MS * CLK_KHZ;
  localparam int RESUME_CARRIERS = 41;      // carrier clocks after modulation
  localparam int RESUME_W        = 6;
  localparam int SYNC_W          = 5;       // pins passed through synchroniser

  // ---------------------------------------------------------------
  // pin carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sleep_request;     // sleep pin level
    logic sleep_driven;      // something drives the sleep pin
    logic modulate_request;  // modulation pin level
    logic modulate_driven;   // something drives the modulation pin
    logic carrier;           // oscillator carrier
    logic short_detect;      // antenna short sensor
    logic compare;           // demodulator comparator output
  } rfr_pins_t;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_SETTLE,
    ST_ACTIVE,
    ST_FAULT
  } rfr_state_t;

endpackage : rfr_pkg

// [hdl/rfr_sync.sv]
module rfr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // system clock
  input  wire logic             srst,  // sync reset, high
  input  wire logic [WIDTH-1:0] din,   // async inputs
  output logic      [WIDTH-1:0] dout   // filtered, synchronised
);

  logic [WIDTH-1:0] f1;
  logic [WIDTH-1:0] f2;
  logic [WIDTH-1:0] f3;
  logic [WIDTH-1:0] next_dout;

  // a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width too small");
  end

  // ---------------------------------------------------------------
  // accept a change only once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (f2[i] == f3[i]) ? f3[i] : dout[i];
    end
  end

  // f1 is read only by f2 to keep metastability contained
  always_ff @(posedge clk) begin
    if (srst) begin
      f1   <= '0;
      f2   <= '0;
      f3   <= '0;
      dout <= '0;
    end else begin
      f1   <= din;
      f2   <= f1;
      f3   <= f2;
      dout <= next_dout;
    end
  end

endmodule : rfr_sync

// [hdl/rfr_ctrl.sv]
module rfr_ctrl
  import rfr_pkg::*;
#(
  parameter int SETTLE_CYC = rfr_pkg::SETTLE_CYCLES,
  parameter int RESUME_CNT = rfr_pkg::RESUME_CARRIERS
) (
  input  wire logic             clk,                  // 200 MHz clock
  input  wire logic             srst,                 // sync reset, high
  input  rfr_pkg::rfr_pins_t    pins,                 // raw pin levels
  output logic                  antenna_drive_a,      // driver A level
  output logic                  antenna_drive_a_oe,   // driver A enabled
  output logic                  antenna_drive_b,      // driver B level
  output logic                  antenna_drive_b_oe,   // driver B enabled
  output logic                  ready_clock,          // ready/clock level
  output logic                  ready_clock_oe,       // ready/clock driven
  output logic                  ready_clock_weak_pd,  // weak pull-down on
  output logic                  demod_chain_run,      // osc/demod chain on
  output logic                  demodulated_data_out  // demodulated data
);
  import rfr_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SETTLE_CYC < 2) begin : g_bad_settle
    $error("settle count too small");
  end
  if (RESUME_CNT < 1 || RESUME_CNT >= (1 << RESUME_W)) begin : g_bad_res
    $error("resume count out of range");
  end

  // ---------------------------------------------------------------
  // pin defaults and synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic              awake_s;
  logic              sleep_s;
  logic              mod_s;
  logic              carrier_s;
  logic              short_s;
  logic              compare_s;

  // undriven pins fall to their internal pull level; sleep travels
  // inverted so the cleared synchroniser reads as asleep after reset
  assign pin_raw = {pins.sleep_driven ? ~pins.sleep_request : 1'b0,
                    pins.modulate_driven ? pins.modulate_request
                                         : 1'b0,
                    pins.carrier, pins.short_detect, pins.compare};

  rfr_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (pin_raw),
    .dout (pin_s)
  );

  assign {awake_s, mod_s, carrier_s, short_s, compare_s} = pin_s;
  assign sleep_s = ~awake_s;

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  rfr_state_t          state;
  rfr_state_t          next_state;
  logic [CNT_W-1:0]    settle_cnt;
  logic [CNT_W-1:0]    next_settle_cnt;
  logic                carrier_q;
  logic                mod_gate;
  logic                next_mod_gate;
  logic [RESUME_W-1:0] resume_cnt;
  logic [RESUME_W-1:0] next_resume_cnt;
  logic                car_rise;

  assign car_rise = carrier_s & ~carrier_q;

  // mode sequencing, settle timer and modulation gate
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    next_mod_gate   = mod_gate;
    next_resume_cnt = resume_cnt;
    // gate follows modulation only on carrier edges
    if (car_rise) begin
      next_mod_gate = mod_s;
      if (mod_gate && !mod_s) begin
        next_resume_cnt = RESUME_W'(RESUME_CNT);
      end else if (mod_s) begin
        next_resume_cnt = '0;
      end else if (resume_cnt != '0) begin
        next_resume_cnt = resume_cnt - 1'b1;
      end
    end
    case (state)
      ST_SLEEP: begin
        next_settle_cnt = '0;
        if (!sleep_s) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_settle_cnt = settle_cnt + 1'b1;
        if (settle_cnt == CNT_W'(SETTLE_CYC - 1)) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        next_settle_cnt = '0;
      end
      ST_FAULT: begin
        next_settle_cnt = '0;
      end
      default: begin
        next_state = ST_SLEEP;
      end
    endcase
    // a short latches until a sleep cycle; sleep wins over all
    if (short_s && (state == ST_SETTLE || state == ST_ACTIVE)) begin
      next_state = ST_FAULT;
    end
    if (sleep_s) begin
      next_state      = ST_SLEEP;
      next_mod_gate   = 1'b0;
      next_resume_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state      <= ST_SLEEP;
      settle_cnt <= '0;
      carrier_q  <= 1'b0;
      mod_gate   <= 1'b0;
      resume_cnt <= '0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
      carrier_q  <= carrier_s;
      mod_gate   <= next_mod_gate;
      resume_cnt <= next_resume_cnt;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers, all registered
  // ---------------------------------------------------------------
  logic powered;
  logic next_ant_a;
  logic next_ant_a_oe;
  logic next_ant_b;
  logic next_ant_b_oe;
  logic next_rdy;
  logic next_rdy_oe;
  logic next_rdy_pd;
  logic next_run;
  logic next_data;

  assign powered = (state == ST_SETTLE) || (state == ST_ACTIVE);

  // ready/clock stays off the antenna until the chain has settled
  always_comb begin
    next_ant_a    = carrier_s;
    next_ant_b    = ~carrier_s;
    next_ant_a_oe = powered && !mod_gate;
    next_ant_b_oe = powered;
    next_rdy      = 1'b0;
    next_rdy_oe   = 1'b1;
    next_rdy_pd   = 1'b0;
    if (state == ST_SETTLE) begin
      next_rdy_oe = 1'b0;
      next_rdy_pd = 1'b1;
    end else if (state == ST_ACTIVE) begin
      next_rdy    = carrier_s;
    end
    next_run  = powered && !mod_gate && (resume_cnt == '0);
    next_data = next_run ? compare_s : demodulated_data_out;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      antenna_drive_a      <= 1'b0;
      antenna_drive_a_oe   <= 1'b0;
      antenna_drive_b      <= 1'b1;
      antenna_drive_b_oe   <= 1'b0;
      ready_clock          <= 1'b0;
      ready_clock_oe       <= 1'b1;
      ready_clock_weak_pd  <= 1'b0;
      demod_chain_run      <= 1'b0;
      demodulated_data_out <= 1'b0;
    end else begin
      antenna_drive_a      <= next_ant_a;
      antenna_drive_a_oe   <= next_ant_a_oe;
      antenna_drive_b      <= next_ant_b;
      antenna_drive_b_oe   <= next_ant_b_oe;
      ready_clock          <= next_rdy;
      ready_clock_oe       <= next_rdy_oe;
      ready_clock_weak_pd  <= next_rdy_pd;
      demod_chain_run      <= next_run;
      demodulated_data_out <= next_data;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  mod_tristate_a: assert property (@(posedge clk) disable iff (srst)
    mod_gate |=> !antenna_drive_a_oe)
    else $error("driver A enabled while modulating");

  mod_keeps_ready_a: assert property (@(posedge clk) disable iff (srst)
    (state == ST_ACTIVE && mod_gate && !sleep_s && !short_s)
      |=> ##1 ready_clock_oe)
    else $error("ready/clock dropped during modulation");

  settle_length_a: assert property (@(posedge clk) disable iff (srst)
    (state == ST_ACTIVE && $past(state) == ST_SETTLE)
      |-> $past(settle_cnt) == CNT_W'(SETTLE_CYC - 1))
    else $error("ready/clock active before settle time");

  settle_weak_a: assert property (@(posedge clk) disable iff (srst)
    state == ST_SETTLE |=> (!ready_clock_oe && ready_clock_weak_pd))
    else $error("ready/clock driven during settle");

  sleep_forces_a: assert property (@(posedge clk) disable iff (srst)
    sleep_s |=> state == ST_SLEEP ##1 (ready_clock_oe && !ready_clock
                                        && !antenna_drive_a_oe))
    else $error("sleep did not force low");

  pin_default_a: assert property (@(posedge clk) disable iff (srst)
    (!pins.sleep_driven && !pins.modulate_driven) [*6] |-> (sleep_s && !mod_s))
    else $error("pin pull defaults not applied");

  resume_load_a: assert property (@(posedge clk) disable iff (srst)
    ($fell(mod_gate) && !$past(sleep_s))
      |-> resume_cnt == RESUME_W'(RESUME_CNT))
    else $error("resume delay not loaded");

  resume_hold_a: assert property (@(posedge clk) disable iff (srst)
    resume_cnt != '0 |=> !demod_chain_run)
    else $error("chain ran during resume delay");

  active_copy_a: assert property (@(posedge clk) disable iff (srst)
    state == ST_ACTIVE |=> (ready_clock_oe && ready_clock == $past(carrier_s)))
    else $error("ready/clock not a carrier copy");

  fault_latch_a: assert property (@(posedge clk) disable iff (srst)
    (state == ST_FAULT && !sleep_s) |=> (state == ST_FAULT
      ##0 (!antenna_drive_a_oe && ready_clock_oe && !ready_clock)))
    else $error("fault not held until sleep");

endmodule : rfr_ctrl

// [dv/rfr_mcu.sv]
module rfr_mcu (
  input  wire logic clk,      // system clock
  input  wire logic srst,     // sync reset, high
  input  wire logic want_mod, // bench asks for modulation
  input  wire logic rc_pin,   // ready/clock wire level
  output logic      mod_pin,  // modulation pin
  output logic      gate,     // discharge-blocking gate
  output logic      data_ok   // demodulated data may be sampled
);
  timeunit 1ns;
  timeprecision 100ps;
  // limits are counted, not timed, so a slow carrier still waits enough
  localparam int WAIT_RC = 14; // rises spanning the bench's 200-cycle settle
  localparam int REC_CYC = 64; // cycles for antenna amplitude recovery
  logic rc_q;
  int   rc_cnt;
  int   rec_cnt;

  // --------------------------------------------------------------
  // controller pin behaviour
  // --------------------------------------------------------------
  // read-only use simply leaves want_mod low, so the pin stays low
  always_ff @(posedge clk) begin
    rc_q    <= rc_pin;
    mod_pin <= want_mod;
    if (srst) begin
      rc_cnt  <= 0;
      rec_cnt <= 0;
      gate    <= 1'b1;
      data_ok <= 1'b0;
    end else begin
      if (rc_pin && !rc_q && rc_cnt < WAIT_RC) begin
        rc_cnt <= rc_cnt + 1;
      end
      data_ok <= (rc_cnt == WAIT_RC);
      if (want_mod) begin
        gate    <= 1'b0;
        rec_cnt <= 0;
      end else if (rec_cnt < REC_CYC) begin
        rec_cnt <= rec_cnt + 1;
      end else begin
        gate <= 1'b1;
      end
    end
  end
endmodule : rfr_mcu

// [dv/rfid_reader_control_pins_tb.sv]
module rfid_reader_control_pins_tb import rfr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, srst, slp, slp_drv, mod_drv, car, shrt, cmp, want_mod;
  logic [3:0] car_cnt;
  logic       a, a_oe, b, b_oe, rc, rc_oe, wpd, run, dout, mod_pin, gate, ok;
  int         err_count, checks;
  rfr_pins_t  pins;
  // watched flags: 0 drv a on, 1 run, 2 rc driven, 3 weak pd, 4 data ok
  wire logic [4:0] mon = {ok, wpd, rc_oe, run, a_oe};
  assign pins = {slp, slp_drv, mod_pin, mod_drv, car, shrt, cmp};

  rfr_ctrl #(.SETTLE_CYC(200), .RESUME_CNT(41)) i_rfr_ctrl (
    .clk(clk), .srst(srst), .pins(pins),
    .antenna_drive_a(a), .antenna_drive_a_oe(a_oe),
    .antenna_drive_b(b), .antenna_drive_b_oe(b_oe),
    .ready_clock(rc), .ready_clock_oe(rc_oe), .ready_clock_weak_pd(wpd),
    .demod_chain_run(run), .demodulated_data_out(dout));
  rfr_mcu i_rfr_mcu (.clk(clk), .srst(srst), .want_mod(want_mod),
    .rc_pin(rc_oe & rc), .mod_pin(mod_pin), .gate(gate), .data_ok(ok));

  // --------------------------------------------------------------
  // clock, carrier (80 ns) and helpers
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    car_cnt <= car_cnt + 4'h1;
    car     <= car_cnt[3];
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int bit_no, input logic v, input int n);
    int k;
    k = 0;
    while (mon[bit_no] !== v && k < n) begin
      cyc(1);
      k++;
    end
    if (mon[bit_no] !== v) begin
      err_count++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask : wait_for

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_sleep();
    cyc(20);
    chk({rc_oe, rc, a_oe, b_oe, run}, 8'h10);
  endtask : t_sleep
  task automatic t_wake();
    slp     <= 1'b0;
    slp_drv <= 1'b1;
    cmp     <= 1'b1;
    cyc(10);
    chk({rc_oe, wpd, run, a_oe, b_oe}, 8'h0f);
    cyc(150);
    chk(rc_oe, 1'b0);
    wait_for(2, 1'b1, 100);
    cyc(2);
    chk(wpd, 1'b0);
    repeat (32) begin
      cyc(1);
      chk(rc, a);
      chk({~b}, rc);
    end
    wait_for(4, 1'b1, 400);
    chk(dout, 1'b1);
  endtask : t_wake
  task automatic t_mod();
    int   n;
    logic p;
    want_mod <= 1'b1;
    cyc(40);
    chk(a_oe, 1'b1);
    mod_drv <= 1'b1;
    wait_for(0, 1'b0, 40);
    cyc(2);
    chk({run, rc_oe, b_oe, gate}, 8'h06);
    n = 0;
    p = rc;
    repeat (64) begin
      cyc(1);
      n += int'(rc && !p);
      p = rc;
    end
    chk(n[7:0], 8'h04);
    want_mod <= 1'b0;
    n = 0;
    p = car;
    while (!run && n < 60) begin
      cyc(1);
      n += int'(car && !p);
      p = car;
    end
    chk(n inside {[42:43]}, 1'b1);
    chk(a_oe, 1'b1);
    chk(gate, 1'b1);
  endtask : t_mod
  task automatic t_short();
    shrt <= 1'b1;
    wait_for(0, 1'b0, 20);
    cyc(2);
    chk({rc_oe, rc, a_oe, b_oe, run}, 8'h10);
    shrt <= 1'b0;
    cyc(40);
    chk({rc_oe, rc, a_oe, run}, 8'h08);
    slp <= 1'b1;
    cyc(10);
    slp <= 1'b0;
    wait_for(3, 1'b1, 20);
    chk(run, 1'b1);
  endtask : t_short

  // main sequence: sleep pin starts undriven, the pull-up holds sleep
  initial begin
    {slp, slp_drv, mod_drv, shrt, cmp, want_mod} = 6'h00;
    car_cnt   = 4'h0;
    car       = 1'b0;
    err_count = 0;
    checks    = 0;
    srst      = 1'b1;
    cyc(16);
    srst <= 1'b0;
    t_sleep();
    t_wake();
    t_mod();
    t_short();
    wrap_up();
  end
endmodule : rfid_reader_control_pins_tb
